// File: hdl/bps_ms_timer.sv
// Millisecond counter that runs while enabled and clears otherwise.
// Assumes a one-cycle ms tick from the parent divider.
`timescale 1ns/1ps
module bps_ms_timer #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic ms_tick,
  input wire logic [W-1:0] limit,
  // Result
  output logic expired
);
  typedef struct packed {
    logic [W-1:0] count;
    logic expired;
  } bps_tmr_type;

  bps_tmr_type s_reg;
  bps_tmr_type s_next;

  always_comb begin
    s_next = s_reg;
    if (!run) begin
      s_next.count = '0;
      s_next.expired = 1'b0;
    end else if (s_reg.count >= limit) begin
      s_next.expired = 1'b1;
    end else if (ms_tick) begin
      s_next.count = s_reg.count + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign expired = s_reg.expired;
endmodule

// File: hdl/bps_sequencer.sv
// Precharge sequencer: qualifies permit, voltage, stability and
// modulation, runs staging and timeout timers, drives bypass and flags.
// Assumes settings are quasi-static from the control clock domain; the
// hardware permit inputs are asynchronous pins.
`timescale 1ns/1ps
module bps_sequencer #(
  parameter int unsigned CYCLES_PER_MS = bps_pkg::CYCLES_PER_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Settings and measurement
  input wire bps_pkg::bps_cfg_type cfg,
  input wire bps_pkg::bps_bus_type bus,
  input wire logic [8*bps_pkg::DIN_COUNT-1:0] din_select,
  input wire logic [bps_pkg::DIN_COUNT-1:0] din_pin,
  // Drive state
  input wire logic [31:0] logic_status,
  input wire logic power_loss,
  // Outputs
  output logic bypass_command,
  output logic run_permit,
  output logic charge_complete_flag,
  output logic bus_undervoltage_flag,
  output logic charging_mode,
  output logic user_permit,
  output logic drive_active,
  output logic charge_timeout_alarm,
  output logic charge_timeout_fault,
  output logic modulation_disable,
  output logic [15:0] motor_control_status,
  output logic [31:0] alarm_status_1
);
  typedef struct packed {
    bps_pkg::bps_state_type state;
    logic [$clog2(CYCLES_PER_MS)-1:0] div;
    logic ms_tick;
    logic [bps_pkg::DIN_COUNT-1:0] sync1;
    logic [bps_pkg::DIN_COUNT-1:0] sync2;
    logic [15+bps_pkg::FILT_SHIFT:0] filt;
    logic undervolt;
    logic stable;
    logic permit_latched;
    logic complete;
    logic bypass;
    logic alarm;
    logic fault;
    logic powerloss_d;
  } bps_seq_type;

  bps_seq_type s_reg;
  bps_seq_type s_next;

  // Any input whose selector holds the permit code
  function automatic logic hw_select(input logic [8*bps_pkg::DIN_COUNT-1:0] sel);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < bps_pkg::DIN_COUNT; i++) begin
      if (sel[8*i +: 8] == bps_pkg::PERMIT_INPUT_CODE) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  logic hw_mode;
  logic hw_permit;
  logic permit_now;
  logic active;
  logic [39:0] uv_product;
  logic [15:0] uv_level;
  logic [15:0] diff;
  logic [15:0] stage_limit;
  logic [15:0] stage_max;
  logic [15:0] stage_ms;
  logic stab_ok;
  logic four_ok;
  logic stage_expired;
  logic tmo_expired;
  logic restart_seq;

  assign active = logic_status[bps_pkg::ACTIVE_BIT];
  assign hw_mode = hw_select(din_select);
  assign hw_permit = |(s_reg.sync2 & {bps_pkg::DIN_COUNT{hw_mode}} & selected_mask(din_select));
  assign permit_now = hw_mode ? hw_permit : cfg.software_charge_permit;

  function automatic logic [bps_pkg::DIN_COUNT-1:0] selected_mask(
      input logic [8*bps_pkg::DIN_COUNT-1:0] sel);
    logic [bps_pkg::DIN_COUNT-1:0] m;
    m = '0;
    for (int i = 0; i < bps_pkg::DIN_COUNT; i++) begin
      m[i] = (sel[8*i +: 8] == bps_pkg::PERMIT_INPUT_CODE);
    end
    return m;
  endfunction

  // Percent times rated volts times root two, in Q14 fixed point
  assign uv_product = 40'(bus.rated_volts) * 40'(bus.undervolt_pct) *
                      40'(bps_pkg::SQRT2_Q14);
  assign uv_level = 16'(uv_product / 40'(100 * 16384));

  logic [15:0] filt_v;
  assign filt_v = 16'(s_reg.filt >> bps_pkg::FILT_SHIFT);

  assign diff = (bus.bus_voltage_reading > filt_v) ?
                (bus.bus_voltage_reading - filt_v) :
                (filt_v - bus.bus_voltage_reading);

  // Clamp to timeout minus one second, then floor at the minimum
  assign stage_max = (cfg.charge_timeout_period > 16'(bps_pkg::STAGE_MARGIN_MS)) ?
                     16'(cfg.charge_timeout_period - 16'(bps_pkg::STAGE_MARGIN_MS)) : '0;
  assign stage_limit = (cfg.stage_delay_setting > stage_max) ? stage_max :
                       cfg.stage_delay_setting;
  assign stage_ms = (stage_limit < 16'(bps_pkg::MIN_STAGE_MS)) ?
                    16'(bps_pkg::MIN_STAGE_MS) : stage_limit;

  // Stability is waived after timeout under any response, ignore included
  assign stab_ok = s_reg.stable || tmo_expired ||
                   (cfg.charge_timeout_response == bps_pkg::RESP_IGNORE && tmo_expired);
  assign four_ok = permit_now && !s_reg.undervolt && stab_ok && !active;

  // Restart on permit or voltage loss only while stopped; coast power loss restarts a running drive too
  assign restart_seq = (s_reg.state == bps_pkg::ST_DONE) &&
                       ((!active && (!permit_now || s_reg.undervolt)) ||
                        (cfg.coast_mode && power_loss && !s_reg.powerloss_d));

  bps_ms_timer #(.W(16)) stage_timer (
    .clk(clk),
    .reset(reset),
    .run(s_reg.state == bps_pkg::ST_STAGE && four_ok),
    .ms_tick(s_reg.ms_tick),
    .limit(stage_ms),
    .expired(stage_expired)
  );

  bps_ms_timer #(.W(16)) timeout_timer (
    .clk(clk),
    .reset(reset),
    .run(s_reg.permit_latched && !s_reg.complete),
    .ms_tick(s_reg.ms_tick),
    .limit(cfg.charge_timeout_period),
    .expired(tmo_expired)
  );

  always_comb begin
    s_next = s_reg;
    s_next.ms_tick = 1'b0;
    if (s_reg.div == ($bits(s_reg.div))'(CYCLES_PER_MS - 1)) begin
      s_next.div = '0;
      s_next.ms_tick = 1'b1;
    end else begin
      s_next.div = s_reg.div + 1'b1;
    end
    s_next.sync1 = din_pin;
    s_next.sync2 = s_reg.sync1;
    s_next.powerloss_d = power_loss;
    // Fraction bits let the filter settle on the bus value itself, not short of it
    s_next.filt = ($bits(s_reg.filt))'(s_reg.filt + bus.bus_voltage_reading
                  - (s_reg.filt >> bps_pkg::FILT_SHIFT));
    s_next.stable = (diff <= bps_pkg::STABLE_WINDOW);
    s_next.undervolt = (bus.bus_voltage_reading < uv_level);
    if (permit_now) begin
      s_next.permit_latched = 1'b1;
    end
    unique case (s_reg.state)
      bps_pkg::ST_CHARGE: begin
        if (four_ok) begin
          s_next.state = bps_pkg::ST_STAGE;
        end
      end
      bps_pkg::ST_STAGE: begin
        if (stage_expired && four_ok) begin
          s_next.state = bps_pkg::ST_DONE;
          s_next.bypass = 1'b1;
          s_next.complete = 1'b1;
        end
      end
      bps_pkg::ST_DONE: begin
        if (restart_seq) begin
          s_next.state = bps_pkg::ST_CHARGE;
          s_next.bypass = 1'b0;
          s_next.complete = 1'b0;
          s_next.permit_latched = permit_now;
        end
      end
    endcase
    // Timeout only reports here; the sequence above sees it only as a stability waiver
    if (tmo_expired && cfg.charge_timeout_response == bps_pkg::RESP_ALARM) begin
      s_next.alarm = 1'b1;
    end
    if (tmo_expired && cfg.charge_timeout_response == bps_pkg::RESP_FAULT) begin
      s_next.fault = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.state <= bps_pkg::ST_CHARGE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bypass_command = s_reg.bypass;
  assign charge_complete_flag = s_reg.complete;
  assign charging_mode = !s_reg.complete;
  assign run_permit = (s_reg.complete || cfg.sim_mode) && !s_reg.fault;
  assign bus_undervoltage_flag = s_reg.undervolt;
  assign user_permit = permit_now;
  assign drive_active = active;
  assign charge_timeout_alarm = s_reg.alarm;
  assign charge_timeout_fault = s_reg.fault;
  assign modulation_disable = s_reg.fault || (cfg.coast_mode && power_loss);

  always_comb begin
    motor_control_status = '0;
    motor_control_status[bps_pkg::COMPLETE_BIT] = s_reg.complete;
    motor_control_status[bps_pkg::UNDERVOLT_BIT] = s_reg.undervolt;
    alarm_status_1 = '0;
    alarm_status_1[bps_pkg::CHARGE_ALARM_BIT] = s_reg.alarm;
  end
endmodule

// File: include/bps_pkg.sv
// Constants, types and carriers for the bus precharge sequencer.
// Assumes one 40 MHz control clock; times are held in milliseconds.
// Function
// - Inhibit running until charging completes
// - Charging mode whenever completion flag is zero
// - Input select code 30 picks permit source
// - Software permit 0 holds, 1 grants
// - Undervoltage flag blocks completion, status bit 15
// - Stability from bus versus filtered bus
// - No charging restart while modulation active
// - Permit withdrawal ignored until modulation stops
// - Staging delay, restarts when any condition drops
// - Staging delay below 200 ms becomes 200
// - Staging delay limited to timeout minus 1 s
// - Timeout period settable, default 30 s
// - Timeout timer starts only with user permit
// - Timeout never alters the charging sequence; the code waives the stability condition once it expires
// - Expired timeout overrides instability only
// - Response 0: no fault, skip stability
// - Response 1: alarm bit 30, no fault
// - Response 2 default: fault, disable modulation
// - Expose active, permit and completion flags
// - Simulation mode ignores charging conditions
// - Coast power loss restarts charging cycle
package bps_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TIME_MS = 1000;
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / TIME_MS;
  localparam int unsigned MIN_STAGE_MS = 200;
  localparam int unsigned STAGE_MARGIN_MS = 1000;
  localparam int unsigned TIMEOUT_DEFAULT_MS = 30_000;
  localparam logic [7:0] PERMIT_INPUT_CODE = 8'h1E;
  localparam int unsigned DIN_COUNT = 6;
  localparam int unsigned COMPLETE_BIT = 11;
  localparam int unsigned UNDERVOLT_BIT = 15;
  localparam int unsigned ACTIVE_BIT = 0;
  localparam int unsigned CHARGE_ALARM_BIT = 30;
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_ALARM = 2'h1;
  localparam logic [1:0] RESP_FAULT = 2'h2;
  localparam logic [15:0] TIMEOUT_RESET = 16'h7530;
  localparam logic [15:0] STAGE_RESET = 16'h0000;
  localparam int unsigned FILT_SHIFT = 6;
  localparam logic [15:0] STABLE_WINDOW = 16'h0008;
  localparam int unsigned SQRT2_Q14 = 23170;

  typedef enum logic [1:0] {ST_CHARGE, ST_STAGE, ST_DONE} bps_state_type;

  typedef struct packed {
    logic [15:0] bus_voltage_reading;
    logic [15:0] rated_volts;
    logic [7:0] undervolt_pct;
  } bps_bus_type;

  typedef struct packed {
    logic software_charge_permit;
    logic [1:0] charge_timeout_response;
    logic [15:0] charge_timeout_period;
    logic [15:0] stage_delay_setting;
    logic sim_mode;
    logic coast_mode;
  } bps_cfg_type;
endpackage

// File: testbench/bps_ext_ctrl.sv
// External precharge controller owning one permit input.
// Assumes the bench routes permit_pin to a digital input.
`timescale 1ns/1ps
module bps_ext_ctrl (
  // Clock
  input wire logic clk,
  // Coordination
  input wire logic power_ok,
  input wire logic request,
  input wire logic charge_complete_flag,
  // Pins
  output logic permit_pin,
  output logic stage_next
);
  // Held back until incoming power is present
  always_ff @(posedge clk) begin
    permit_pin <= request && power_ok;
  end
  // Next drive of a group may be permitted once this one is done
  assign stage_next = charge_complete_flag;
endmodule

// File: testbench/bps_sequencer_checker.sv
// Assertions on the precharge sequencer ports.
// Assumes a bind onto bps_sequencer; one clock domain.
`timescale 1ns/1ps
module bps_sequencer_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Inputs
  input wire bps_pkg::bps_cfg_type cfg,
  input wire logic [8*bps_pkg::DIN_COUNT-1:0] din_select,
  input wire logic power_loss,
  // Outputs
  input wire logic bypass_command,
  input wire logic run_permit,
  input wire logic charge_complete_flag,
  input wire logic bus_undervoltage_flag,
  input wire logic charging_mode,
  input wire logic user_permit,
  input wire logic drive_active,
  input wire logic charge_timeout_alarm,
  input wire logic charge_timeout_fault,
  input wire logic modulation_disable,
  input wire logic [15:0] motor_control_status,
  input wire logic [31:0] alarm_status_1
);
  logic sel_hw;
  always_comb begin
    sel_hw = 1'b0;
    for (int i = 0; i < bps_pkg::DIN_COUNT; i++) begin
      if (din_select[8*i+:8] == bps_pkg::PERMIT_INPUT_CODE) begin
        sel_hw = 1'b1;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_run;
    run_permit |-> (charge_complete_flag || cfg.sim_mode) && !charge_timeout_fault;
  endproperty
  a_run: assert property (p_run) else $error("run without completion");
  property p_mode;
    charging_mode == !motor_control_status[11];
  endproperty
  a_mode: assert property (p_mode) else $error("mode flag");
  property p_soft;
    !sel_hw |-> user_permit == cfg.software_charge_permit;
  endproperty
  a_soft: assert property (p_soft) else $error("permit source");
  property p_uv;
    motor_control_status[15] == bus_undervoltage_flag;
  endproperty
  a_uv: assert property (p_uv) else $error("undervolt bit");
  property p_hold;
    drive_active && charge_complete_flag && !cfg.coast_mode |=> charge_complete_flag;
  endproperty
  a_hold: assert property (p_hold) else $error("restart while active");
  property p_bypass;
    $rose(charge_complete_flag) |-> bypass_command;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass late");
  property p_fault;
    charge_timeout_fault |-> modulation_disable ##1 charge_timeout_fault;
  endproperty
  a_fault: assert property (p_fault) else $error("fault stop");
  property p_alarm;
    $rose(charge_timeout_alarm) |-> alarm_status_1[30]
      && $past(cfg.charge_timeout_response) == bps_pkg::RESP_ALARM;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm source");
  property p_nofault;
    $rose(charge_timeout_fault) |-> $past(cfg.charge_timeout_response) == bps_pkg::RESP_FAULT;
  endproperty
  a_nofault: assert property (p_nofault) else $error("fault source");
  property p_coast;
    cfg.coast_mode && power_loss |-> modulation_disable;
  endproperty
  a_coast: assert property (p_coast) else $error("coast stop");
  c_alarm: cover property ($rose(charge_timeout_alarm));
  c_fault: cover property ($rose(charge_timeout_fault));
  c_hw: cover property (sel_hw && user_permit);
  c_done: cover property ($rose(charge_complete_flag));
endmodule
bind bps_sequencer bps_sequencer_checker i_chk (.clk(clk), .reset(reset), .cfg(cfg),
  .din_select(din_select), .power_loss(power_loss), .bypass_command(bypass_command),
  .run_permit(run_permit), .charge_complete_flag(charge_complete_flag),
  .bus_undervoltage_flag(bus_undervoltage_flag), .charging_mode(charging_mode),
  .user_permit(user_permit), .drive_active(drive_active),
  .charge_timeout_alarm(charge_timeout_alarm), .charge_timeout_fault(charge_timeout_fault),
  .modulation_disable(modulation_disable), .motor_control_status(motor_control_status),
  .alarm_status_1(alarm_status_1));

// File: testbench/bps_sequencer_tb.sv
// Self-checking bench for the precharge sequencer.
// Assumes the checker binds itself; the partner owns input 2.
`timescale 1ns/1ps
module bps_sequencer_tb;
  logic clk = 1'b0;
  logic reset, power_ok, request, permit_pin, power_loss;
  logic [5:0] pin_tb;
  logic [5:0] din_pin;
  logic [31:0] logic_status;
  logic [8*bps_pkg::DIN_COUNT-1:0] din_select;
  bps_pkg::bps_cfg_type cfg;
  bps_pkg::bps_bus_type bus;
  logic bypass_command, run_permit, charge_complete_flag, bus_undervoltage_flag;
  logic charging_mode, user_permit, drive_active, charge_timeout_alarm;
  logic charge_timeout_fault, modulation_disable;
  logic [15:0] motor_control_status;
  logic [31:0] alarm_status_1;
  int n_errors = 0;
  int num_checks = 0;
  always #12.5 clk = ~clk;
  assign din_pin = pin_tb | {3'h0, permit_pin, 2'h0};
  bps_ext_ctrl i_ext (.clk(clk), .power_ok(power_ok), .request(request),
    .charge_complete_flag(charge_complete_flag), .permit_pin(permit_pin), .stage_next());
  // A 40-cycle millisecond keeps the 200 ms staging run short
  bps_sequencer #(.CYCLES_PER_MS(40)) i_dut (.clk(clk), .reset(reset), .cfg(cfg), .bus(bus),
    .din_select(din_select), .din_pin(din_pin), .logic_status(logic_status),
    .power_loss(power_loss), .bypass_command(bypass_command), .run_permit(run_permit),
    .charge_complete_flag(charge_complete_flag),
    .bus_undervoltage_flag(bus_undervoltage_flag), .charging_mode(charging_mode),
    .user_permit(user_permit), .drive_active(drive_active),
    .charge_timeout_alarm(charge_timeout_alarm),
    .charge_timeout_fault(charge_timeout_fault), .modulation_disable(modulation_disable),
    .motor_control_status(motor_control_status), .alarm_status_1(alarm_status_1));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset;
    @(posedge clk);
    reset <= 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    step(2);
  endtask
  // Timeout of 1 ms expires within two ms ticks of the permit
  task automatic wait_hi(input logic [1:0] sel);
    int k;
    k = 0;
    while ((sel == 2'h0 ? charge_timeout_alarm : sel == 2'h1 ? charge_timeout_fault :
        charge_complete_flag) !== 1'b1 && k < 12000) begin
      step(1);
      k++;
    end
    if (k >= 12000) begin
      n_errors++;
      report_and_stop();
    end
  endtask
  initial begin
    reset = 1'b1;
    cfg = '0;
    cfg.charge_timeout_response = bps_pkg::RESP_ALARM;
    cfg.charge_timeout_period = 16'h0001;
    bus = {16'h0048, 16'h0064, 8'h32};
    din_select = '0;
    pin_tb = 6'h00;
    logic_status = 32'h0;
    power_loss = 1'b0;
    request = 1'b1;
    power_ok = 1'b1;
    do_reset();
    check({charging_mode, run_permit, bypass_command}, 32'h4);
    @(posedge clk);
    cfg.software_charge_permit <= 1'b1;
    step(1);
    check(user_permit, 32'h1);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      din_select <= 48'h1E << (8 * i);
      step(4);
      check(user_permit, (i == 2) ? 32'h1 : 32'h0);
    end
    @(posedge clk);
    din_select <= 48'h1E0000;
    power_ok <= 1'b0;
    step(4);
    check(user_permit, 32'h0);
    $display("permit test done");
    @(posedge clk);
    din_select <= '0;
    bus.bus_voltage_reading <= 16'h0045;
    step(3);
    check({motor_control_status[15], bus_undervoltage_flag}, 32'h3);
    @(posedge clk);
    bus.bus_voltage_reading <= 16'h0048;
    logic_status <= 32'h1;
    cfg.coast_mode <= 1'b1;
    power_loss <= 1'b1;
    step(3);
    check({bus_undervoltage_flag, drive_active, modulation_disable}, 32'h3);
    @(posedge clk);
    cfg.coast_mode <= 1'b0;
    cfg.sim_mode <= 1'b1;
    step(1);
    check({modulation_disable, run_permit, charging_mode}, 32'h3);
    @(posedge clk);
    logic_status <= 32'h0;
    power_loss <= 1'b0;
    $display("status test done");
    wait_hi(2'h0);
    check({charge_timeout_fault, alarm_status_1[30], charging_mode}, 32'h3);
    $display("alarm test done");
    @(posedge clk);
    cfg.charge_timeout_response <= bps_pkg::RESP_FAULT;
    do_reset();
    wait_hi(2'h1);
    check({modulation_disable, run_permit, charging_mode}, 32'h5);
    $display("fault test done");
    @(posedge clk);
    cfg.charge_timeout_response <= bps_pkg::RESP_ALARM;
    cfg.charge_timeout_period <= 16'h07D0;
    cfg.sim_mode <= 1'b0;
    do_reset();
    step(7800);
    check({charge_complete_flag, run_permit}, 32'h0);
    wait_hi(2'h2);
    check({bypass_command, run_permit, charging_mode}, 32'h6);
    check(motor_control_status, 32'h0800);
    @(posedge clk);
    logic_status <= 32'h1;
    cfg.software_charge_permit <= 1'b0;
    step(3);
    check({charge_complete_flag, user_permit}, 32'h2);
    @(posedge clk);
    logic_status <= 32'h0;
    step(2);
    check({charge_complete_flag, bypass_command, charging_mode}, 32'h1);
    $display("completion test done");
    report_and_stop();
  end
endmodule
